// >>> shared/gpdic_pkg.sv
package gpdic_pkg;

    // Bus address limits and factory default
    localparam logic [4:0] GPDIC_ADDR_MAX     = 5'h1e;
    localparam logic [4:0] GPDIC_ADDR_DEFAULT = 5'h10;

    // Interface clear minimum hold time, nanoseconds
    localparam int GPDIC_IFC_MIN_NS = 100000;
    localparam int GPDIC_CLK_NS     = 100;
    localparam int GPDIC_IFC_CYCLES = GPDIC_IFC_MIN_NS / GPDIC_CLK_NS;

    // Front panel key vector layout
    localparam int GPDIC_KEY_W     = 8;
    localparam int GPDIC_KEY_LOCAL = 0;
    localparam int GPDIC_KEY_TRIG  = 1;
    localparam int GPDIC_KEY_OUTOF = 2;

    // Trigger control source encoding
    typedef enum logic [1:0]
    {
        GPDIC_TRIG_IMM,
        GPDIC_TRIG_BUS,
        GPDIC_TRIG_MAN,
        GPDIC_TRIG_EXT
    } gpdic_trig_src_t;

    // Decoded bus command strobe codes
    typedef enum logic [3:0]
    {
        GPDIC_CMD_NONE,
        GPDIC_CMD_MLA,
        GPDIC_CMD_MTA,
        GPDIC_CMD_OTA,
        GPDIC_CMD_UNL,
        GPDIC_CMD_UNT,
        GPDIC_CMD_LLO,
        GPDIC_CMD_GTL,
        GPDIC_CMD_DCL,
        GPDIC_CMD_SDC,
        GPDIC_CMD_GET,
        GPDIC_CMD_SPE,
        GPDIC_CMD_SPD
    } gpdic_cmd_t;

endpackage : gpdic_pkg

// >>> hdl/gpdic_srq.sv
`timescale 1ns/1ps
module gpdic_srq
    import gpdic_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic srq_cond,
    input  wire logic poll_read,
    output logic      srq_active
);

    logic srq_q;
    logic srq_d;

    // Set on new condition; held until poll read or conditions gone
    always_comb
    begin
        srq_d = srq_q;
        if (!srq_cond)
            srq_d = 1'b0;
        else if (poll_read)
            srq_d = 1'b0;
        else
            srq_d = 1'b1;
    end

    // A read only drops the flag until the condition rises again
    logic cond_q;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            cond_q <= 1'b0;
        else
            cond_q <= srq_cond;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            srq_q <= 1'b0;
        else if (srq_cond && !cond_q)
            srq_q <= 1'b1; // Rising condition wins over read
        else if (!srq_cond || poll_read)
            srq_q <= srq_d;
    end

    assign srq_active = srq_q;

    a_srq_poll_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (poll_read && cond_q && srq_cond) |=> !srq_active)
        else $error("srq stayed on after poll read");

    a_srq_cond_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!srq_cond) |=> !srq_active)
        else $error("srq stayed on with no condition");

endmodule : gpdic_srq

// >>> hdl/gpdic_ctrl.sv
`timescale 1ns/1ps
// Operation
// - Remote entered only when addressed to listen while remote enable true.
// - Reading commands accepted only while in remote state.
// - Interface clear forces local, talker idle, listener idle.
// - Interface clear leaves settings, data and event registers untouched.
// - Local lockout disables all front-panel keys except output-off; here the trigger key also stays live with manual trigger source.
// - Lockout cancelled by go-to-local and by power cycle.
// - Go-to-local moves remote device to local, re-enables keys.
// - Universal device clear acted on without being addressed.
// - Device clear flushes buffers, cancels deferred and blocking commands.
// - Device clear leaves settings and stored data unchanged.
// - Selective device clear acts only when device is addressed.
// - Group trigger advances trigger model only with bus trigger source.
// - Status byte returned on serial poll at any time.
// - In remote, every front-panel key except local is locked out.
// - Manual trigger source keeps trigger key active in remote.
// - Talker active on own talk address; idle on untalk, listen, clear.
// - Listener active on own listen address; idle on unlisten, talk, clear.
// - Service request held until poll read or causes cleared.
// - Local key cancels remote, indicator off, restores normal display.
// - Local key ignored while local lockout in effect.
// - Primary address 0 to 30, default 16; only matching addresses answered.
module gpdic_ctrl
    import gpdic_pkg::*;
#(
    parameter int IFC_CYCLES = GPDIC_IFC_CYCLES
)
(
    input  wire logic                         clk_sys,
    input  wire logic                         rst_n,
    input  wire logic                         ren,
    input  wire logic                         ifc,
    input  wire logic                         cmd_valid,
    input  wire gpdic_pkg::gpdic_cmd_t        cmd,
    input  wire logic [4:0]                   cmd_addr,
    input  wire logic                         addr_wr,
    input  wire logic [4:0]                   addr_wdata,
    input  wire gpdic_pkg::gpdic_trig_src_t   trig_src,
    input  wire logic [GPDIC_KEY_W-1:0]       key_raw,
    input  wire logic                         reading_cmd,
    input  wire logic [7:0]                   status_byte,
    input  wire logic                         srq_cond,
    output logic [4:0]                        bus_addr,
    output logic                              remote_state_indicator,
    output logic                              listener_active_indicator,
    output logic                              talker_active,
    output logic                              lockout,
    output logic [GPDIC_KEY_W-1:0]            key_enabled,
    output logic                              reading_accept,
    output logic                              dev_clear,
    output logic                              bus_trigger,
    output logic                              display_restore,
    output logic                              poll_mode,
    output logic [7:0]                        poll_byte,
    output logic                              srq_active
);
    import gpdic_pkg::*;

    // A zero hold count would let every glitch on ifc act as a clear
    if (IFC_CYCLES < 1)
    begin : g_bad_ifc_cycles
        $error("IFC_CYCLES must be at least one");
    end

    // Interface clear is qualified by its hold time so glitches do nothing
    logic [$clog2(IFC_CYCLES+1)-1:0] ifc_cnt_q;
    logic                            ifc_hit;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ifc_cnt_q <= '0;
        else if (!ifc)
            ifc_cnt_q <= '0;
        else if (ifc_cnt_q != IFC_CYCLES[$clog2(IFC_CYCLES+1)-1:0])
            ifc_cnt_q <= ifc_cnt_q + 1'b1;
    end

    assign ifc_hit = (ifc_cnt_q == IFC_CYCLES[$clog2(IFC_CYCLES+1)-1:0]);

    // Address match helper used by talk and listen decode
    function automatic logic addr_match(input logic [4:0] a, input logic [4:0] mine);
        addr_match = (a == mine);
    endfunction : addr_match

    // Programmable primary address; out-of-range writes are dropped
    logic [4:0] addr_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            addr_q <= GPDIC_ADDR_DEFAULT;
        else if (addr_wr && addr_wdata <= GPDIC_ADDR_MAX)
            addr_q <= addr_wdata;
    end

    assign bus_addr = addr_q;

    // Command decode strobes
    logic c_mla;
    logic c_mta;
    logic c_local_key;

    assign c_mla = cmd_valid && cmd == GPDIC_CMD_MLA && addr_match(cmd_addr, addr_q);
    assign c_mta = cmd_valid && cmd == GPDIC_CMD_MTA && addr_match(cmd_addr, addr_q);
    assign c_local_key = key_raw[GPDIC_KEY_LOCAL];

    // Listener state
    logic lsn_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            lsn_q <= 1'b0;
        else if (ifc_hit)
            lsn_q <= 1'b0;
        else if (c_mla)
            lsn_q <= 1'b1;
        else if (c_mta)
            lsn_q <= 1'b0;
        else if (cmd_valid && cmd == GPDIC_CMD_UNL)
            lsn_q <= 1'b0;
    end

    // Talker state; another device's talk address also idles us
    logic tlk_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            tlk_q <= 1'b0;
        else if (ifc_hit)
            tlk_q <= 1'b0;
        else if (c_mta)
            tlk_q <= 1'b1;
        else if (c_mla)
            tlk_q <= 1'b0;
        else if (cmd_valid && (cmd == GPDIC_CMD_UNT || cmd == GPDIC_CMD_OTA))
            tlk_q <= 1'b0;
    end

    // Lockout latch; reset stands in for a power cycle
    logic llo_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            llo_q <= 1'b0;
        else if (!ren)
            llo_q <= 1'b0;
        else if (cmd_valid && cmd == GPDIC_CMD_GTL && lsn_q)
            llo_q <= 1'b0;
        else if (cmd_valid && cmd == GPDIC_CMD_LLO)
            llo_q <= 1'b1;
    end

    // Remote state; interface clear drops remote
    logic rem_q;
    logic local_ok;

    assign local_ok = c_local_key && !llo_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rem_q <= 1'b0;
        else if (!ren)
            rem_q <= 1'b0;
        else if (ifc_hit)
            rem_q <= 1'b0;
        else if (cmd_valid && cmd == GPDIC_CMD_GTL && lsn_q)
            rem_q <= 1'b0;
        else if (local_ok && rem_q)
            rem_q <= 1'b0;
        else if (c_mla)
            rem_q <= 1'b1;
    end

    // Display restore pulse when the local key leaves remote
    logic disp_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            disp_q <= 1'b0;
        else
            disp_q <= local_ok && rem_q && ren && !ifc_hit;
    end

    // Front-panel gating: output-off live under lockout, trigger live on manual
    always_comb
    begin
        key_enabled = '1;
        if (llo_q)
        begin
            key_enabled = '0;
            key_enabled[GPDIC_KEY_OUTOF] = 1'b1;
        end
        else if (rem_q)
        begin
            key_enabled = '0;
            key_enabled[GPDIC_KEY_LOCAL] = 1'b1;
        end
        if ((rem_q || llo_q) && trig_src == GPDIC_TRIG_MAN)
            key_enabled[GPDIC_KEY_TRIG] = 1'b1;
    end

    // Device clear pulse; settings and data live elsewhere and are untouched
    logic dcl_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            dcl_q <= 1'b0;
        else
            dcl_q <= cmd_valid && (cmd == GPDIC_CMD_DCL
                     || (cmd == GPDIC_CMD_SDC && lsn_q));
    end

    // Bus trigger pulse
    logic get_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            get_q <= 1'b0;
        else
            get_q <= cmd_valid && cmd == GPDIC_CMD_GET && lsn_q
                     && trig_src == GPDIC_TRIG_BUS;
    end

    // Serial poll mode and captured byte
    logic       spm_q;
    logic [7:0] pbyte_q;
    logic       poll_read;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            spm_q <= 1'b0;
        else if (ifc_hit)
            spm_q <= 1'b0;
        else if (cmd_valid && cmd == GPDIC_CMD_SPE)
            spm_q <= 1'b1;
        else if (cmd_valid && cmd == GPDIC_CMD_SPD)
            spm_q <= 1'b0;
    end

    // Byte captured with the request bit folded into bit 6
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            pbyte_q <= 8'h00;
        else if (spm_q && c_mta)
            pbyte_q <= {status_byte[7], srq_active, status_byte[5:0]};
    end

    // Poll read happens when addressed to talk while in poll mode
    assign poll_read = spm_q && c_mta;

    gpdic_srq u_srq
    (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .srq_cond   (srq_cond),
        .poll_read  (poll_read),
        .srq_active (srq_active)
    );

    // Settings, data and event registers have no path from ifc here
    assign reading_accept = reading_cmd && rem_q;

    assign remote_state_indicator    = rem_q;
    assign listener_active_indicator = lsn_q;
    assign talker_active             = tlk_q;
    assign lockout                   = llo_q;
    assign dev_clear                 = dcl_q;
    assign bus_trigger               = get_q;
    assign display_restore           = disp_q;
    assign poll_mode                 = spm_q;
    assign poll_byte                 = pbyte_q;

    a_rem_needs_mla: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(remote_state_indicator) |-> $past(c_mla) && $past(ren))
        else $error("remote entered without listen address");

    a_read_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reading_accept |-> remote_state_indicator)
        else $error("reading accepted in local");

    a_ifc_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ifc_hit |=> !remote_state_indicator && !listener_active_indicator
                    && !talker_active)
        else $error("interface clear did not idle");

    a_llo_keys: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lockout |-> key_enabled[GPDIC_KEY_OUTOF] && !key_enabled[GPDIC_KEY_LOCAL])
        else $error("lockout key gating wrong");

    a_gtl_local: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_valid && cmd == GPDIC_CMD_GTL && lsn_q) |=> !remote_state_indicator
                                                         && !lockout)
        else $error("go to local ignored");

    a_dcl_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_valid && cmd == GPDIC_CMD_DCL) |=> dev_clear)
        else $error("device clear missed");

    a_get_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_trigger |-> $past(trig_src) == GPDIC_TRIG_BUS)
        else $error("trigger without bus source");

    a_remote_keys: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (remote_state_indicator && !lockout) |-> key_enabled[GPDIC_KEY_LOCAL]
        && (key_enabled[GPDIC_KEY_TRIG] == (trig_src == GPDIC_TRIG_MAN)))
        else $error("remote key gating wrong");

    a_local_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (lockout && remote_state_indicator && ren && !ifc_hit && !cmd_valid)
        |=> remote_state_indicator)
        else $error("local key acted under lockout");

    a_ren_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ren |=> !remote_state_indicator && !lockout)
        else $error("remote kept with ren false");

    a_sdc_addressed: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_valid && cmd == GPDIC_CMD_SDC && !lsn_q) |=> !dev_clear)
        else $error("selective clear acted while unaddressed");

    a_ota_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_valid && cmd == GPDIC_CMD_OTA) |=> !talker_active)
        else $error("talker kept after other talk address");

    a_talk_listen_excl: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(talker_active && listener_active_indicator))
        else $error("talker and listener both active");

    a_remote_outoff: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (remote_state_indicator && !lockout) |-> !key_enabled[GPDIC_KEY_OUTOF])
        else $error("output-off key live in remote");

endmodule : gpdic_ctrl

// >>> verif/gpdic_bus_model.sv
`timescale 1ns/1ps
module gpdic_bus_model
#(
    parameter int IFC_CYCLES = 4
)
(
    input  wire logic             clk_sys,
    output logic                  ren,
    output logic                  ifc,
    output logic                  cmd_valid,
    output gpdic_pkg::gpdic_cmd_t cmd,
    output logic [4:0]            cmd_addr
);
    import gpdic_pkg::*;

    // Bus lines idle at time zero
    initial
    begin
        ren       = 1'b0;
        ifc       = 1'b0;
        cmd_valid = 1'b0;
        cmd       = GPDIC_CMD_NONE;
        cmd_addr  = 5'h00;
    end

    // One command cycle; address inverts on release so stale bits never match
    task automatic send(input gpdic_cmd_t c, input logic [4:0] a);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd       <= c;
        cmd_addr  <= a;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd       <= GPDIC_CMD_NONE;
        cmd_addr  <= ~a;
        #1;
    endtask : send

    // Remote enable line level
    task automatic set_ren(input logic v);
        @(posedge clk_sys);
        ren <= v;
        #1;
    endtask : set_ren

    // Full hold meets the minimum; short hold breaks it on purpose
    task automatic clear(input bit short_hold);
        int n;
        n = short_hold ? IFC_CYCLES - 1 : IFC_CYCLES + 1;
        @(posedge clk_sys);
        ifc <= 1'b1;
        repeat (n) @(posedge clk_sys);
        ifc <= 1'b0;
        #1;
    endtask : clear
endmodule : gpdic_bus_model

// >>> verif/tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module tb;
    import gpdic_pkg::*;
    localparam int         IFCN = 4;
    localparam logic [4:0] ME   = GPDIC_ADDR_DEFAULT;
    logic            clk_sys = 1'b0;
    logic            rst_n   = 1'b0;
    logic            ren, ifc, cmd_valid, addr_wr, reading_cmd, srq_cond;
    gpdic_cmd_t      cmd;
    logic [4:0]      cmd_addr, addr_wdata, bus_addr;
    gpdic_trig_src_t trig_src;
    logic [7:0]      key_raw, status_byte, key_enabled, poll_byte;
    logic            remote_state_indicator, listener_active_indicator, talker_active;
    logic            lockout, reading_accept, dev_clear, bus_trigger;
    logic            display_restore, poll_mode, srq_active;
    int              errors      = 0;
    int              check_count = 0;

    // 10 MHz system clock
    always #50 clk_sys = ~clk_sys;

    gpdic_bus_model #(.IFC_CYCLES(IFCN)) gpdic_bus_model_inst (.clk_sys(clk_sys), .ren(ren),
        .ifc(ifc), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr));

    // Short interface clear count keeps the run brief
    gpdic_ctrl #(.IFC_CYCLES(IFCN)) gpdic_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .ren(ren), .ifc(ifc), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr),
        .addr_wr(addr_wr), .addr_wdata(addr_wdata), .trig_src(trig_src), .key_raw(key_raw),
        .reading_cmd(reading_cmd), .status_byte(status_byte), .srq_cond(srq_cond),
        .bus_addr(bus_addr), .remote_state_indicator(remote_state_indicator),
        .listener_active_indicator(listener_active_indicator), .talker_active(talker_active),
        .lockout(lockout), .key_enabled(key_enabled), .reading_accept(reading_accept),
        .dev_clear(dev_clear), .bus_trigger(bus_trigger), .display_restore(display_restore),
        .poll_mode(poll_mode), .poll_byte(poll_byte), .srq_active(srq_active));

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic snd(input gpdic_cmd_t c, input logic [4:0] a);
        gpdic_bus_model_inst.send(c, a);
    endtask : snd

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
    endtask : do_reset

    // One cycle press of the local key
    task automatic press_local();
        @(posedge clk_sys);
        key_raw <= 8'h01;
        @(posedge clk_sys);
        key_raw <= 8'h00;
        #1;
    endtask : press_local

    task automatic t_remote();
        `CHK(bus_addr, GPDIC_ADDR_DEFAULT);
        `CHK(key_enabled, 8'hff);
        snd(GPDIC_CMD_MLA, ME);
        `CHK(remote_state_indicator, 1'b0);
        gpdic_bus_model_inst.set_ren(1'b1);
        snd(GPDIC_CMD_UNL, 5'h00);
        tick(3);
        `CHK(remote_state_indicator, 1'b0);
        snd(GPDIC_CMD_MLA, 5'h05);
        `CHK(listener_active_indicator, 1'b0);
        snd(GPDIC_CMD_MLA, ME);
        `CHK(remote_state_indicator, 1'b1);
        @(posedge clk_sys);
        reading_cmd <= 1'b1;
        tick(1);
        `CHK(reading_accept, 1'b1);
        `CHK(key_enabled, 8'h01);
        @(posedge clk_sys);
        trig_src <= GPDIC_TRIG_MAN;
        tick(1);
        `CHK(key_enabled, 8'h03);
        gpdic_bus_model_inst.set_ren(1'b0);
        tick(1);
        `CHK(remote_state_indicator, 1'b0);
        `CHK(reading_accept, 1'b0);
        @(posedge clk_sys);
        trig_src    <= GPDIC_TRIG_IMM;
        reading_cmd <= 1'b0;
    endtask : t_remote

    task automatic t_address();
        do_reset();
        snd(GPDIC_CMD_MTA, 5'h05);
        `CHK(talker_active, 1'b0);
        snd(GPDIC_CMD_MTA, ME);
        `CHK(talker_active, 1'b1);
        snd(GPDIC_CMD_MLA, ME);
        `CHK(talker_active, 1'b0);
        `CHK(listener_active_indicator, 1'b1);
        snd(GPDIC_CMD_MTA, ME);
        `CHK(listener_active_indicator, 1'b0);
        snd(GPDIC_CMD_UNT, 5'h00);
        `CHK(talker_active, 1'b0);
        snd(GPDIC_CMD_MLA, ME);
        snd(GPDIC_CMD_UNL, 5'h00);
        `CHK(listener_active_indicator, 1'b0);
        snd(GPDIC_CMD_MTA, ME);
        `CHK(talker_active, 1'b1);
        snd(GPDIC_CMD_OTA, 5'h00);
        `CHK(talker_active, 1'b0);
    endtask : t_address

    // A clear shorter than the minimum hold must not act
    task automatic t_ifc();
        gpdic_bus_model_inst.set_ren(1'b1);
        snd(GPDIC_CMD_MLA, ME);
        gpdic_bus_model_inst.clear(1'b1);
        tick(2);
        `CHK(listener_active_indicator, 1'b1);
        gpdic_bus_model_inst.clear(1'b0);
        tick(2);
        `CHK(remote_state_indicator, 1'b0);
        `CHK(listener_active_indicator, 1'b0);
        `CHK(bus_addr, ME);
        snd(GPDIC_CMD_MTA, ME);
        gpdic_bus_model_inst.clear(1'b0);
        tick(2);
        `CHK(talker_active, 1'b0);
    endtask : t_ifc

    task automatic t_lockout();
        snd(GPDIC_CMD_MLA, ME);
        snd(GPDIC_CMD_LLO, 5'h00);
        tick(1);
        `CHK(key_enabled, 8'h04);
        press_local();
        `CHK(remote_state_indicator, 1'b1);
        snd(GPDIC_CMD_GTL, 5'h00);
        tick(1);
        `CHK(remote_state_indicator, 1'b0);
        `CHK(lockout, 1'b0);
        `CHK(key_enabled, 8'hff);
        snd(GPDIC_CMD_MLA, ME);
        snd(GPDIC_CMD_LLO, 5'h00);
        gpdic_bus_model_inst.set_ren(1'b0);
        tick(1);
        `CHK(lockout, 1'b0);
        gpdic_bus_model_inst.set_ren(1'b1);
        snd(GPDIC_CMD_MLA, ME);
        snd(GPDIC_CMD_LLO, 5'h00);
        do_reset();
        `CHK(lockout, 1'b0);
        snd(GPDIC_CMD_MLA, ME);
        press_local();
        `CHK(remote_state_indicator, 1'b0);
        `CHK(display_restore, 1'b1);
    endtask : t_lockout

    task automatic t_clear_trig();
        do_reset();
        snd(GPDIC_CMD_DCL, 5'h00);
        `CHK(dev_clear, 1'b1);
        snd(GPDIC_CMD_SDC, 5'h00);
        `CHK(dev_clear, 1'b0);
        snd(GPDIC_CMD_MLA, ME);
        snd(GPDIC_CMD_SDC, 5'h00);
        `CHK(dev_clear, 1'b1);
        `CHK(bus_addr, ME);
        // Every trigger source; only the bus source fires
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            trig_src <= gpdic_trig_src_t'(i);
            snd(GPDIC_CMD_GET, 5'h00);
            `CHK(bus_trigger, (i == 1));
        end
    endtask : t_clear_trig

    task automatic t_poll();
        @(posedge clk_sys);
        status_byte <= 8'ha5;
        srq_cond    <= 1'b1;
        tick(6);
        `CHK(srq_active, 1'b1);
        snd(GPDIC_CMD_SPE, 5'h00);
        `CHK(poll_mode, 1'b1);
        snd(GPDIC_CMD_MTA, ME);
        tick(1);
        `CHK(poll_byte, 8'he5);
        `CHK(srq_active, 1'b0);
        snd(GPDIC_CMD_SPD, 5'h00);
        `CHK(poll_mode, 1'b0);
        snd(GPDIC_CMD_SPE, 5'h00);
        @(posedge clk_sys);
        status_byte <= 8'h5a;
        snd(GPDIC_CMD_MTA, ME);
        tick(1);
        `CHK(poll_byte, 8'h1a);
        @(posedge clk_sys);
        srq_cond <= 1'b0;
        tick(2);
        @(posedge clk_sys);
        srq_cond <= 1'b1;
        tick(2);
        `CHK(srq_active, 1'b1);
        @(posedge clk_sys);
        srq_cond <= 1'b0;
        tick(2);
        `CHK(srq_active, 1'b0);
    endtask : t_poll

    task automatic t_addr_write();
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_sys);
            addr_wr    <= 1'b1;
            addr_wdata <= 5'h1e + 5'(i);
            @(posedge clk_sys);
            addr_wr    <= 1'b0;
            tick(1);
            `CHK(bus_addr, GPDIC_ADDR_MAX);
        end
        snd(GPDIC_CMD_UNL, 5'h00);
        snd(GPDIC_CMD_MLA, ME);
        `CHK(listener_active_indicator, 1'b0);
        snd(GPDIC_CMD_MLA, GPDIC_ADDR_MAX);
        `CHK(listener_active_indicator, 1'b1);
    endtask : t_addr_write

    // Run cut short if anything hangs
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("wrong value at %0t: run timed out", $time);
        give_verdict();
    end

    initial
    begin
        addr_wr     = 1'b0;
        addr_wdata  = 5'h00;
        trig_src    = GPDIC_TRIG_IMM;
        key_raw     = 8'h00;
        reading_cmd = 1'b0;
        status_byte = 8'h00;
        srq_cond    = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        tick(1);
        t_remote();
        t_address();
        t_ifc();
        t_lockout();
        t_clear_trig();
        t_poll();
        t_addr_write();
        give_verdict();
    end
endmodule : tb
